// [hdl/ufl_ctrl.sv]
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "ufl_regs.svh"
// Contract
// - Receive FIFO reset empties FIFO and count, then self-clears.
// - Enable bit one enables both FIFOs, zero disables; resets zero.
// - Other FIFO control bits are ignored unless the same write sets enable.
// - Trigger field bits 7..6 select 1, 4, 8 or 14 characters.
// - Identification read returns highest-priority pending source.
// - Lower sources hidden while higher pending; re-read reveals the next.
// - Codes 000110 line error, 000100 data ready, 001100 timeout.
// - Codes 000010 holding register empty, 000000 modem change.
// - Codes 010000 Xoff or special character, 100000 CTS/RTS change.
// - Bits 5 and 4 reported only with enhanced enable bit 4 set.
// - Xoff bit stays one until matching Xon characters are received.
// - Bits 7..6 read one with FIFOs enabled, zero otherwise.
// - Bit 0 reads zero when any interrupt pending, one otherwise.
// - Line bit 7 redirects accesses to divisor and enhanced registers.
// - Line bit 6 holds the serial output low until cleared.
// - Line bits 1..0 set character length; reset zero.
// - Line bit 2 selects stop length with word length; reset zero.
// - Bit 3 enables parity, bit 4 even, bit 5 forces parity.
// - Stop bit one gives 1.5 stops for 5 bits, else 2.
// - Length codes select 5, 6, 7 or 8 data bits.

module ufl_ctrl
    import ufl_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Register port
    input  wire logic [`UFL_ADDR_W-1:0]  addr,
    input  wire logic [7:0]              wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output logic      [7:0]              rdata,
    // Receive side character stream
    input  wire logic                    rx_valid,
    input  wire logic [7:0]              rx_char,
    input  wire logic                    rx_pop,
    output logic      [7:0]              rx_head,
    output logic                         rx_empty,
    output logic                         rx_full,
    output logic                         rx_trig,
    // Interrupt source levels from the channel
    input  wire logic                    line_err,
    input  wire logic                    rx_timeout,
    input  wire logic                    thr_empty,
    input  wire logic                    modem_chg,
    input  wire logic                    flow_chg,
    input  wire logic                    xoff_seen,
    input  wire logic                    xon_seen,
    // Serial output and format
    input  wire logic                    tx_bit,
    output logic                         tx_line,
    output ufl_fmt_s                     fmt,
    output logic                         fifo_en,
    output logic                         tx_fifo_rst,
    output logic                         dlab,
    output logic                         irq
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0] fc_q;
    logic [7:0] lf_q;
    logic [7:0] efr_q;
    logic       xoff_q;
    logic       rx_rst_q;
    logic       tx_rst_q;
    logic [7:0] mem_q [`UFL_DEPTH];
    logic [`UFL_PTR_W-1:0] wp_q;
    logic [`UFL_PTR_W-1:0] rp_q;
    logic [`UFL_CNT_W-1:0] cnt_q;

    // Access decode; line bit 7 moves offset 5 onto the enhanced register
    wire wr_fc  = wr && addr == `UFL_ADR_FIFO_CTL && !lf_q[`UFL_LF_DLAB];
    wire wr_lf  = wr && addr == `UFL_ADR_LINE_FMT;
    wire wr_efr = wr && addr == `UFL_ADR_EFR && lf_q[`UFL_LF_DLAB];
    wire fc_ok  = wdata[`UFL_FC_EN];

    // ----------------------------------------------------------------
    // FIFO control
    // ----------------------------------------------------------------
    // A write with enable clear only turns the FIFOs off; other fields
    // keep their previous settings.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fc_q     <= 8'h00;
            rx_rst_q <= 1'b0;
            tx_rst_q <= 1'b0;
        end
        else
        begin
            rx_rst_q <= wr_fc && fc_ok && wdata[`UFL_FC_RX_RST];
            tx_rst_q <= wr_fc && fc_ok && wdata[`UFL_FC_TX_RST];
            if (wr_fc && fc_ok)
                fc_q <= {wdata[7:3], 2'b00, 1'b1};
            else if (wr_fc)
                fc_q[`UFL_FC_EN] <= 1'b0;
        end
    end

    assign fifo_en     = fc_q[`UFL_FC_EN];
    assign tx_fifo_rst = tx_rst_q;

    // ----------------------------------------------------------------
    // Line format and enhanced feature registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lf_q  <= `UFL_LF_RST;
            efr_q <= 8'h00;
        end
        else
        begin
            if (wr_lf)
                lf_q <= wdata;
            if (wr_efr)
                efr_q <= wdata;
        end
    end

    assign dlab = lf_q[`UFL_LF_DLAB];

    // Format decode for transmitter and receiver
    wire [3:0] len_bits = {2'b00, lf_q[1:0]} + 4'h5;
    wire       five     = lf_q[1:0] == 2'b00;
    assign fmt.data_bits     = len_bits;
    assign fmt.parity_en     = lf_q[`UFL_LF_PAR_EN];
    assign fmt.parity_even   = lf_q[`UFL_LF_EVEN];
    assign fmt.parity_forced = lf_q[`UFL_LF_STICK];
    assign fmt.parity_value  = !lf_q[`UFL_LF_EVEN]; // Forced 1 when bit 4 low
    // Stop length in half bit times: 2 or 3; two stop bits encode as 0
    assign fmt.stop_halves   = !lf_q[`UFL_LF_STOP] ? 2'h2 :
                               five ? 2'h3 : 2'h0;
    assign fmt.brk           = lf_q[`UFL_LF_BREAK];

    // Break overrides the serial bit for as long as the bit stays set
    assign tx_line = tx_bit && !lf_q[`UFL_LF_BREAK];

    // ----------------------------------------------------------------
    // Receive FIFO
    // ----------------------------------------------------------------
    // Without FIFO mode the store acts as a one-character holding register.
    wire [`UFL_CNT_W-1:0] cap = fifo_en ? 5'h10 : 5'h01;
    wire do_push = rx_valid && cnt_q < cap;
    wire do_pop  = rx_pop && cnt_q != 5'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else if (rx_rst_q)
        begin
            // Pointers and count only; the mem_q storage array keeps its contents
            wp_q  <= 4'h0;
            rp_q  <= 4'h0;
            cnt_q <= 5'h00;
        end
        else
        begin
            if (do_push)
                wp_q <= wp_q + 4'h1;
            if (do_pop)
                rp_q <= rp_q + 4'h1;
            cnt_q <= cnt_q + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    // Storage needs no reset; pointers define what is valid
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem_q[wp_q] <= rx_char;
    end

    assign rx_head  = mem_q[rp_q];
    assign rx_empty = cnt_q == 5'h00;
    assign rx_full  = cnt_q == cap;

    // Threshold from the trigger field
    logic [`UFL_CNT_W-1:0] trig_lvl;
    always_comb
    begin
        case (fc_q[`UFL_FC_TRIG_HI:`UFL_FC_TRIG_LO])
            2'b00:   trig_lvl = `UFL_TRIG_00;
            2'b01:   trig_lvl = `UFL_TRIG_01;
            2'b10:   trig_lvl = `UFL_TRIG_10;
            default: trig_lvl = `UFL_TRIG_11;
        endcase
    end
    assign rx_trig = fifo_en ? cnt_q >= trig_lvl : !rx_empty;

    // ----------------------------------------------------------------
    // Xoff latch and interrupt identification
    // ----------------------------------------------------------------
    // Xoff wins over an Xon in the same cycle so the event is not lost
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            xoff_q <= 1'b0;
        else if (xoff_seen)
            xoff_q <= 1'b1;
        else if (xon_seen)
            xoff_q <= 1'b0;
    end

    wire enh = efr_q[`UFL_EF_ENH];
    ufl_src_s src;
    assign src.line_err   = line_err;
    assign src.rx_data    = rx_trig;
    assign src.rx_timeout = rx_timeout && fifo_en;
    assign src.thr_empty  = thr_empty;
    assign src.modem      = modem_chg;
    assign src.xoff       = xoff_q && enh;
    assign src.flow       = flow_chg && enh;

    // Priority encoder: the first hit masks all below it
    logic [5:0] id_code;
    always_comb
    begin
        if (src.line_err)        id_code = `UFL_ID_LINE;
        else if (src.rx_timeout) id_code = `UFL_ID_TIMEOUT;
        else if (src.rx_data)    id_code = `UFL_ID_RXDATA;
        else if (src.thr_empty)  id_code = `UFL_ID_THR;
        else if (src.modem)      id_code = `UFL_ID_MODEM;
        else if (src.xoff)       id_code = `UFL_ID_XOFF;
        else if (src.flow)       id_code = `UFL_ID_FLOW;
        else                     id_code = `UFL_ID_NONE;
    end
    // Live encoding: once a source is serviced the next one shows

    wire [7:0] id_val = {{2{fifo_en}}, id_code};
    assign irq = !id_code[0];

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    wire [7:0] status = {3'h0, xoff_q, rx_full, rx_empty, dlab, fifo_en};
    wire [7:0] rd_mux = addr == `UFL_ADR_INT_ID && !dlab ? id_val :
                        addr == `UFL_ADR_LINE_FMT       ? lf_q   :
                        addr == `UFL_ADR_EFR && dlab    ? efr_q  :
                        addr == `UFL_ADR_STATUS         ? status :
                        8'h00;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (rd)
            rdata <= rd_mux;
        else
            rdata <= 8'h00;
    end

endmodule // ufl_ctrl

// [hdl/ufl_regs.svh]
`ifndef UFL_REGS_SVH
`define UFL_REGS_SVH

// Register addresses on the plain register port
`define UFL_ADDR_W        3
`define UFL_ADR_FIFO_CTL  3'h2
`define UFL_ADR_INT_ID    3'h2
`define UFL_ADR_LINE_FMT  3'h3
`define UFL_ADR_SRC_SET   3'h4
`define UFL_ADR_EFR       3'h5
`define UFL_ADR_STATUS    3'h6

// fifo_control bit positions
`define UFL_FC_EN         0
`define UFL_FC_RX_RST     1
`define UFL_FC_TX_RST     2
`define UFL_FC_DMA        3
`define UFL_FC_TRIG_HI    7
`define UFL_FC_TRIG_LO    6

// line_format_control bit positions and reset value
`define UFL_LF_RST        8'h00
`define UFL_LF_DLAB       7
`define UFL_LF_BREAK      6
`define UFL_LF_STICK      5
`define UFL_LF_EVEN       4
`define UFL_LF_PAR_EN     3
`define UFL_LF_STOP       2

// Enhanced feature enable bit
`define UFL_EF_ENH        4

// Trigger levels in characters
`define UFL_TRIG_00       5'h01
`define UFL_TRIG_01       5'h04
`define UFL_TRIG_10       5'h08
`define UFL_TRIG_11       5'h0e

// Identification codes, bits 5..0
`define UFL_ID_LINE       6'h06
`define UFL_ID_RXDATA     6'h04
`define UFL_ID_TIMEOUT    6'h0c
`define UFL_ID_THR        6'h02
`define UFL_ID_MODEM      6'h00
`define UFL_ID_XOFF       6'h10
`define UFL_ID_FLOW       6'h20
`define UFL_ID_NONE       6'h01

// Receive FIFO geometry
`define UFL_DEPTH         16
`define UFL_PTR_W         4
`define UFL_CNT_W         5

`endif

// [hdl/ufl_pkg.sv]
package ufl_pkg;

    // Priority sources of the interrupt identification
    typedef struct packed {
        logic line_err;
        logic rx_data;
        logic rx_timeout;
        logic thr_empty;
        logic modem;
        logic xoff;
        logic flow;
    } ufl_src_s;

    // Character format handed to transmitter and receiver
    typedef struct packed {
        logic [3:0] data_bits;
        logic       parity_en;
        logic       parity_even;
        logic       parity_forced;
        logic       parity_value;
        logic [1:0] stop_halves;
        logic       brk;
    } ufl_fmt_s;

endpackage

// [tb/ufl_checker.sv]
`timescale 1ns/1ns
`include "ufl_regs.svh"
// ---------
// Port checker
// ---------
module ufl_checker
    import ufl_pkg::*;
(
    // Clock, reset and register port
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic [`UFL_ADDR_W-1:0] addr,
    input wire logic [7:0]             wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [7:0]             rdata,
    // Status, line and format
    input wire logic                   rx_empty,
    input wire logic                   line_err,
    input wire logic                   tx_line,
    input wire ufl_fmt_s               fmt,
    input wire logic                   fifo_en,
    input wire logic                   dlab,
    input wire logic                   irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Decoded accesses; the id window is hidden while dlab is set
    wire id_rd = rd && addr == `UFL_ADR_INT_ID && !dlab;
    wire lf_wr = wr && addr == `UFL_ADR_LINE_FMT;
    wire fc_wr = wr && addr == `UFL_ADR_FIFO_CTL && !dlab;

    brk_low_a: assert property (fmt.brk |-> !tx_line)
        else $error("break bit set but line high");
    id_pend_a: assert property (id_rd |=> rdata[0] == !$past(irq))
        else $error("pending bit disagrees with irq");
    id_fifo_a: assert property (
        id_rd |=> rdata[7:6] == {2{$past(fifo_en)}})
        else $error("fifo mode bits wrong");
    id_line_a: assert property (
        id_rd && line_err |=> rdata[5:0] == `UFL_ID_LINE)
        else $error("line error not on top");
    fmt_len_a: assert property (
        lf_wr |=> fmt.data_bits == 4'h5 + $past(wdata[1:0]))
        else $error("word length wrong");
    fmt_stop_a: assert property (lf_wr |=> fmt.stop_halves ==
        (!$past(wdata[2]) ? 2'h2 : $past(wdata[1:0]) == 2'h0 ? 2'h3 : 2'h0))
        else $error("stop length wrong");
    fmt_par_a: assert property (lf_wr |=> fmt.parity_en ==
        $past(wdata[3]) && fmt.parity_even == $past(wdata[4]) &&
        fmt.parity_forced == $past(wdata[5]))
        else $error("parity selection wrong");
    dlab_set_a: assert property (lf_wr |=> dlab == $past(wdata[7]))
        else $error("divisor access bit wrong");
    fen_wr_a: assert property (fc_wr |=> fifo_en == $past(wdata[0]))
        else $error("fifo enable not taken");
    rx_clr_a: assert property (
        fc_wr && wdata[1:0] == 2'h3 |-> ##2 rx_empty)
        else $error("receive fifo not cleared");
endmodule // ufl_checker

// [tb/ufl_far_end.sv]
`timescale 1ns/1ns
// ---------
// Far-end channel model
// ---------
module ufl_far_end
(
    // Clock and bench command
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic [7:0] ch,
    // Toward the block
    output logic            rx_valid = 1'b0,
    output logic [7:0]      rx_char = 8'h00,
    output logic            tx_bit = 1'b1
);
    // Idle data is inverted each cycle so a stale byte never looks valid
    always @(posedge clk)
    begin
        rx_valid <= send;
        rx_char  <= send ? ch : ~rx_char;
        tx_bit   <= ~tx_bit;
    end
endmodule // ufl_far_end

// [tb/tb_uart_fifo_irq_line_control.sv]
`timescale 1ns/1ns
`include "ufl_regs.svh"
module tb_uart_fifo_irq_line_control;
    import ufl_pkg::*;
    // ---------
    // Signals
    // ---------
    logic       clk, rx_valid, rx_empty, rx_full, rx_trig, tx_bit;
    logic       tx_line, fifo_en, dlab, irq;
    logic       rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_pop = 1'b0;
    logic       send = 1'b0, xoff_seen = 1'b0, xon_seen = 1'b0;
    logic       line_err = 0, rx_timeout = 0, thr_empty = 0;
    logic       modem_chg = 0, flow_chg = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, ch = 8'h00, rdata, rx_char, rx_head, d;
    ufl_fmt_s   fmt;
    int         miscompares, num_checks, n;
    int         lvl[4] = '{1, 4, 8, 14};
    logic [4:0] src_v[5] = '{5'h1f, 5'h0f, 5'h07, 5'h03, 5'h01};
    logic [7:0] id_v[5] = '{8'hc6, 8'hcc, 8'hc2, 8'hc0, 8'he0};

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ufl_ctrl DUT (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .rx_valid,
        .rx_char, .rx_pop, .rx_head, .rx_empty, .rx_full, .rx_trig,
        .line_err, .rx_timeout, .thr_empty, .modem_chg, .flow_chg,
        .xoff_seen, .xon_seen, .tx_bit, .tx_line, .fmt, .fifo_en,
        .tx_fifo_rst(), .dlab, .irq);
    ufl_far_end u_far (.clk, .send, .ch, .rx_valid, .rx_char, .tx_bit);

    // ---------
    // Tasks
    // ---------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Strobes drop and a gap cycle follows, so calls never collide
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e,
                        input string what);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, e, what);
        @(posedge clk);
    endtask
    task automatic push(input logic [7:0] v);
        ch   <= v;
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(posedge clk);
        @(posedge clk);
    endtask
    task automatic pop;
        rx_pop <= 1'b1;
        @(posedge clk);
        rx_pop <= 1'b0;
        @(posedge clk);
    endtask

    // ---------
    // Sequence
    // ---------
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rreg(`UFL_ADR_INT_ID, 8'h01, "id reset");
        rreg(`UFL_ADR_LINE_FMT, 8'h00, "line reset");
        check(fifo_en, 8'h00, "fifo_en reset");
        // Every word length, both stop settings, parity fields
        for (int i = 0; i < 4; i++)
        begin
            d = (i[0] ? 8'h08 : 8'h3c) | 8'(i);
            wreg(`UFL_ADR_LINE_FMT, d);
            rreg(`UFL_ADR_LINE_FMT, d, "line");
            check(8'(fmt.data_bits), 8'(5 + i), "bits");
            check(fmt.stop_halves, d[2] ? (i == 0 ? 8'h3 : 8'h0) : 8'h2,
                  "stop");
            check({fmt.parity_en, fmt.parity_even}, {d[3], d[4]}, "par");
        end
        wreg(`UFL_ADR_LINE_FMT, 8'h43);
        repeat (3)
        begin
            #1 check(tx_line, 8'h00, "break");
            @(posedge clk);
        end
        wreg(`UFL_ADR_LINE_FMT, 8'h83);
        #1 check(tx_line, tx_bit, "break off");
        check(dlab, 8'h01, "dlab");
        rreg(`UFL_ADR_INT_ID, 8'h00, "id hidden");
        wreg(`UFL_ADR_EFR, 8'h10);
        wreg(`UFL_ADR_LINE_FMT, 8'h03);
        // Control bits without the enable must be ignored
        wreg(`UFL_ADR_FIFO_CTL, 8'hc2);
        rreg(`UFL_ADR_STATUS, 8'h04, "status");
        for (int c = 0; c < 4; c++)
        begin
            wreg(`UFL_ADR_FIFO_CTL, {c[1:0], 6'h03});
            #1 check(rx_empty, 8'h01, "rx cleared");
            @(posedge clk);
            n = 0;
            while (rx_trig !== 1'b1 && n < 20)
            begin
                push(8'h40 + 8'(n));
                n++;
            end
            check(8'(n), 8'(lvl[c]), "trigger");
            if (c == 0)
                rreg(`UFL_ADR_INT_ID, 8'hc4, "id data");
        end
        push(8'h4e);
        push(8'h4f);
        push(8'hff);
        check(rx_full, 8'h01, "full");
        for (int k = 0; k < 16; k++)
        begin
            check(rx_head, 8'h40 + 8'(k), "head");
            pop();
        end
        // Sources drop one by one from the top of the priority ladder
        for (int i = 0; i < 5; i++)
        begin
            {line_err, rx_timeout, thr_empty, modem_chg, flow_chg} <= src_v[i];
            @(posedge clk);
            rreg(`UFL_ADR_INT_ID, id_v[i], "id prio");
        end
        xoff_seen <= 1'b1;
        @(posedge clk);
        xoff_seen <= 1'b0;
        flow_chg  <= 1'b0;
        rreg(`UFL_ADR_INT_ID, 8'hd0, "xoff");
        xon_seen <= 1'b1;
        @(posedge clk);
        xon_seen <= 1'b0;
        flow_chg <= 1'b1;
        rreg(`UFL_ADR_INT_ID, 8'he0, "xon");
        wreg(`UFL_ADR_LINE_FMT, 8'h83);
        wreg(`UFL_ADR_EFR, 8'h00);
        wreg(`UFL_ADR_LINE_FMT, 8'h03);
        rreg(`UFL_ADR_INT_ID, 8'hc1, "id no enh");
        print_verdict();
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule // tb_uart_fifo_irq_line_control

bind ufl_ctrl ufl_checker u_chk (.clk, .rst, .addr, .wdata, .wr, .rd,
    .rdata, .rx_empty, .line_err, .tx_line, .fmt, .fifo_en, .dlab, .irq);
